// File: pkg/tsq_pkg.sv
/*
 * Shared constants for the transceiver reset sequencer and its controller.
 * Assumes a single 20 MHz management clock shared by both ends.
 */
`default_nettype none
package tsq_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PLL_PD_NS     = 1000;
    localparam int PLL_PD_CYC    = (PLL_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_SETTLE_NS  = 4000;
    localparam int RX_SETTLE_CYC = (RX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIG_HOLD_CYC = 2;
    localparam int CAL_CYC_DEF   = 64;
    localparam int NUM_CH_DEF    = 4;
    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] PLL_PD_LAST    = CNT_W'(PLL_PD_CYC - 1);
    localparam logic [CNT_W-1:0] RX_SETTLE_LAST = CNT_W'(RX_SETTLE_CYC - 1);
    localparam logic [1:0]       HOLD_LAST      = 2'(TRIG_HOLD_CYC - 1);

    localparam logic [3:0]  OFS_CTRL     = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h4;
    localparam logic [3:0]  OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0]  OFS_IRQ_MASK = 4'hC;
    localparam int          CTRL_RUN     = 0;
    localparam int          CTRL_RESTART = 1;
    localparam logic        CTRL_RUN_RST = 1'h1;
    localparam int          ST_TXRDY     = 0;
    localparam int          ST_RXRDY     = 1;
    localparam int          ST_DLOCK     = 2;
    localparam int          ST_RLOCK     = 3;
    localparam int          ST_CAL       = 4;
    localparam int          ST_RSTOUT    = 5;
    localparam int          IRQ_W        = 4;
    localparam int          IRQ_TXUP     = 0;
    localparam int          IRQ_RXUP     = 1;
    localparam int          IRQ_LOST     = 2;
    localparam int          IRQ_CALDONE  = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    typedef enum logic [2:0] {
        TX_HOLD  = 3'h0,
        TX_CAL   = 3'h1,
        TX_PLLPD = 3'h2,
        TX_LOCK  = 3'h3,
        TX_RUN   = 3'h4
    } tsq_tx_state_type;

    typedef enum logic [2:0] {
        RX_HOLD   = 3'h0,
        RX_WAIT   = 3'h1,
        RX_LOCK   = 3'h2,
        RX_SETTLE = 3'h3,
        RX_RUN    = 3'h4
    } tsq_rx_state_type;

    typedef enum logic [1:0] {
        CAL_OFF   = 2'h0,
        CAL_FIRST = 2'h1,
        CAL_BUSY  = 2'h2,
        CAL_DONE  = 2'h3
    } tsq_cal_state_type;
endpackage : tsq_pkg
`default_nettype wire

// File: pkg/tsq_link_if.sv
/*
 * Link between the reset sequencer and the controlling logic.
 * Assumes both ends run on the same management clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface tsq_link_if;
    logic seqTrigRst;
    logic calBusy;
    logic txReady;
    logic rxReady;
    logic cdrDataLockFlag;
    logic cdrRefLockFlag;

    modport seq (
        input  seqTrigRst,
        input  calBusy,
        output txReady,
        output rxReady,
        output cdrDataLockFlag,
        output cdrRefLockFlag
    );

    modport ctl (
        output seqTrigRst,
        output calBusy,
        input  txReady,
        input  rxReady,
        input  cdrDataLockFlag,
        input  cdrRefLockFlag
    );
endinterface : tsq_link_if
`default_nettype wire

// File: src/tsq_sequencer.sv
/*
 * Embedded reset sequencer driving the PLL, PMA and PCS resets of all
 * channels of one transceiver instance.
 * Assumes lock inputs arrive asynchronously from the channels and that the
 * calibration busy flag is produced on the same management clock.
 */
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tsq_sequencer
    import tsq_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    tsq_link_if.seq                link,
    input  wire logic              pllLock,
    input  wire logic [NUM_CH-1:0] cdrRefLock,
    input  wire logic [NUM_CH-1:0] cdrDataLock,
    output var  logic              pllPowerdown,
    output var  logic [NUM_CH-1:0] txPmaReset,
    output var  logic [NUM_CH-1:0] txPcsReset,
    output var  logic [NUM_CH-1:0] rxPmaReset,
    output var  logic [NUM_CH-1:0] rxPcsReset
);

    // ***********************************************************************
    // Elaboration checks.
    // ***********************************************************************
    if (NUM_CH < 1) begin : gChkCh
        $error("NUM_CH must be at least one.");
    end
    if (PLL_PD_CYC >= 2**CNT_W || RX_SETTLE_CYC >= 2**CNT_W) begin : gChkCnt
        $error("Timing counts exceed the counter width.");
    end

    // ***********************************************************************
    // Input synchronisers.
    // ***********************************************************************
    localparam int SYNC_W = 2 * NUM_CH + 2;

    logic [SYNC_W-1:0] asyncIn;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    assign asyncIn = {link.seqTrigRst, pllLock, cdrRefLock, cdrDataLock};

    for (genvar i = 0; i < SYNC_W; i++) begin : gSync
        always_ff @(posedge sys_clk) begin
            meta_q[i] <= asyncIn[i];
            sync_q[i] <= meta_q[i];
        end
    end

    logic              trigHigh;
    logic              pllLockS;
    logic [NUM_CH-1:0] refLockS;
    logic [NUM_CH-1:0] dataLockS;
    logic              trigPrev_q;
    logic              trigFall;

    assign {trigHigh, pllLockS, refLockS, dataLockS} = sync_q;
    assign trigFall = trigPrev_q & ~trigHigh;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trigPrev_q <= 1'b1;
        end else begin
            trigPrev_q <= trigHigh;
        end
    end

    // ***********************************************************************
    // Calibration tracking.
    // ***********************************************************************
    logic calSeen_q;
    logic calSeen_d;
    logic calDone;

    assign calSeen_d = trigHigh ? 1'b0 : (calSeen_q | link.calBusy);
    assign calDone   = calSeen_q & ~link.calBusy;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            calSeen_q <= 1'b0;
        end else begin
            calSeen_q <= calSeen_d;
        end
    end

    // ***********************************************************************
    // Transmit sequence.
    // ***********************************************************************
    tsq_tx_state_type txState_q;
    tsq_tx_state_type txState_d;
    logic [CNT_W-1:0] txCnt_q;
    logic [CNT_W-1:0] txCnt_d;
    logic             txCntEnd;

    assign txCntEnd = (txCnt_q == PLL_PD_LAST);

    always_comb begin
        txState_d = txState_q;
        txCnt_d   = '0;
        case (txState_q)
            TX_HOLD: begin
                if (trigFall) begin
                    txState_d = TX_CAL;
                end
            end
            TX_CAL: begin
                if (calDone) begin
                    txState_d = TX_PLLPD;
                end
            end
            TX_PLLPD: begin
                txCnt_d = txCnt_q + CNT_W'(1);
                if (txCntEnd) begin
                    txState_d = TX_LOCK;
                end
            end
            TX_LOCK: begin
                if (pllLockS) begin
                    txState_d = TX_RUN;
                end
            end
            TX_RUN: begin
                if (!pllLockS) begin
                    txState_d = TX_LOCK;
                end
            end
            default: begin
                txState_d = TX_HOLD;
            end
        endcase
        if (trigHigh) begin
            txState_d = TX_HOLD;
        end
    end

    // ***********************************************************************
    // Receive sequence.
    // ***********************************************************************
    tsq_rx_state_type rxState_q;
    tsq_rx_state_type rxState_d;
    logic [CNT_W-1:0] rxCnt_q;
    logic [CNT_W-1:0] rxCnt_d;
    logic             allDataLock;
    logic             rxCntEnd;

    assign allDataLock = &dataLockS;
    assign rxCntEnd    = (rxCnt_q == RX_SETTLE_LAST);

    always_comb begin
        rxState_d = rxState_q;
        rxCnt_d   = '0;
        case (rxState_q)
            RX_HOLD: begin
                if (trigFall) begin
                    rxState_d = RX_WAIT;
                end
            end
            RX_WAIT: begin
                if (calDone) begin
                    rxState_d = RX_LOCK;
                end
            end
            RX_LOCK: begin
                if (allDataLock) begin
                    rxState_d = RX_SETTLE;
                end
            end
            RX_SETTLE: begin
                rxCnt_d = rxCnt_q + CNT_W'(1);
                if (!allDataLock) begin
                    rxState_d = RX_LOCK;
                end else if (rxCntEnd) begin
                    rxState_d = RX_RUN;
                end
            end
            RX_RUN: begin
                if (!allDataLock) begin
                    rxState_d = RX_LOCK;
                end
            end
            default: begin
                rxState_d = RX_HOLD;
            end
        endcase
        if (trigHigh) begin
            rxState_d = RX_HOLD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txState_q <= TX_HOLD;
            rxState_q <= RX_HOLD;
            txCnt_q   <= '0;
            rxCnt_q   <= '0;
        end else begin
            txState_q <= txState_d;
            rxState_q <= rxState_d;
            txCnt_q   <= txCnt_d;
            rxCnt_q   <= rxCnt_d;
        end
    end

    // ***********************************************************************
    // Registered reset and status outputs, shared by all channels.
    // ***********************************************************************
    logic pllPd_d;
    logic txPma_d;
    logic txPcs_d;
    logic rxPma_d;
    logic rxPcs_d;
    logic dataFlag_d;
    logic refFlag_d;

    assign pllPd_d    = (txState_d == TX_HOLD) || (txState_d == TX_CAL) || (txState_d == TX_PLLPD);
    assign txPma_d    = pllPd_d;
    assign txPcs_d    = (txState_d != TX_RUN);
    assign rxPma_d    = (rxState_d == RX_HOLD) || (rxState_d == RX_WAIT);
    assign rxPcs_d    = (rxState_d != RX_RUN);
    assign dataFlag_d = allDataLock & ~rxPma_d;
    assign refFlag_d  = (&refLockS) & ~rxPma_d;

    logic pllPd_q;
    logic txPma_q;
    logic txPcs_q;
    logic rxPma_q;
    logic rxPcs_q;
    logic txReady_q;
    logic rxReady_q;
    logic dataFlag_q;
    logic refFlag_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pllPd_q    <= 1'b1;
            txPma_q    <= 1'b1;
            txPcs_q    <= 1'b1;
            rxPma_q    <= 1'b1;
            rxPcs_q    <= 1'b1;
            txReady_q  <= 1'b0;
            rxReady_q  <= 1'b0;
            dataFlag_q <= 1'b0;
            refFlag_q  <= 1'b0;
        end else begin
            pllPd_q    <= pllPd_d;
            txPma_q    <= txPma_d;
            txPcs_q    <= txPcs_d;
            rxPma_q    <= rxPma_d;
            rxPcs_q    <= rxPcs_d;
            txReady_q  <= (txState_d == TX_RUN);
            rxReady_q  <= (rxState_d == RX_RUN);
            dataFlag_q <= dataFlag_d;
            refFlag_q  <= refFlag_d;
        end
    end

    assign pllPowerdown         = pllPd_q;
    assign txPmaReset           = {NUM_CH{txPma_q}};
    assign txPcsReset           = {NUM_CH{txPcs_q}};
    assign rxPmaReset           = {NUM_CH{rxPma_q}};
    assign rxPcsReset           = {NUM_CH{rxPcs_q}};
    assign link.txReady         = txReady_q;
    assign link.rxReady         = rxReady_q;
    assign link.cdrDataLockFlag = dataFlag_q;
    assign link.cdrRefLockFlag  = refFlag_q;

endmodule : tsq_sequencer
`default_nettype wire

// File: src/tsq_controller.sv
/*
 * Controlling logic: drives the sequence trigger reset, models the
 * calibration busy flag, and offers software registers on a memory-mapped
 * slave with waitrequest and one interrupt line.
 * Assumes the reference clock stable indication arrives asynchronously.
 */
`timescale 1ns/100ps
`default_nettype none
module tsq_controller
    import tsq_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYC_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    tsq_link_if.ctl          link,
    input  wire logic        refClkStable,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        irq,
    output var  logic        txUsable,
    output var  logic        rxUsable
);

    // ***********************************************************************
    // Elaboration checks.
    // ***********************************************************************
    if (CAL_CYCLES < 1 || CAL_CYCLES >= 2**16) begin : gChkCal
        $error("CAL_CYCLES out of range.");
    end

    // ***********************************************************************
    // Bus slave.
    // ***********************************************************************
    logic        waitReq_q;
    logic [31:0] rdData_q;
    logic        readTake;
    logic        readAcc;
    logic        writeAcc;
    logic [31:0] rdMux;
    logic        ctrlRun_q;
    logic        restart_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic        rstOut_q;
    tsq_cal_state_type calState_q;
    tsq_cal_state_type calState_d;

    assign readTake = avs_read & waitReq_q;
    assign readAcc  = avs_read & ~waitReq_q;
    assign writeAcc = avs_write & ~waitReq_q;

    always_comb begin
        rdMux = 32'h0;
        case (avs_address)
            OFS_CTRL: begin
                rdMux[CTRL_RUN] = ctrlRun_q;
            end
            OFS_STATUS: begin
                rdMux[ST_TXRDY]  = link.txReady;
                rdMux[ST_RXRDY]  = link.rxReady;
                rdMux[ST_DLOCK]  = link.cdrDataLockFlag;
                rdMux[ST_RLOCK]  = link.cdrRefLockFlag;
                rdMux[ST_CAL]    = link.calBusy;
                rdMux[ST_RSTOUT] = rstOut_q;
            end
            OFS_IRQ_STAT: begin
                rdMux[IRQ_W-1:0] = irqStat_q;
            end
            OFS_IRQ_MASK: begin
                rdMux[IRQ_W-1:0] = irqMask_q;
            end
            default: begin
                rdMux = 32'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitReq_q <= 1'b1;
            rdData_q  <= 32'h0;
        end else begin
            waitReq_q <= ~((avs_read | avs_write) & waitReq_q);
            if (readTake) begin
                rdData_q <= rdMux;
            end
        end
    end

    // ***********************************************************************
    // Control and interrupt registers.
    // ***********************************************************************
    logic             refSyncA_q;
    logic             refSync_q;
    logic             txPrev_q;
    logic             rxPrev_q;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irqClr;
    logic             wrCtrl;
    logic             calFinish;

    assign wrCtrl    = writeAcc && (avs_address == OFS_CTRL);
    assign calFinish = (calState_q == CAL_BUSY) && (calState_d == CAL_DONE);
    assign events[IRQ_TXUP]    = link.txReady & ~txPrev_q;
    assign events[IRQ_RXUP]    = link.rxReady & ~rxPrev_q;
    assign events[IRQ_LOST]    = (txPrev_q & ~link.txReady) | (rxPrev_q & ~link.rxReady);
    assign events[IRQ_CALDONE] = calFinish;
    assign irqClr = (readAcc && (avs_address == OFS_IRQ_STAT)) ? rdData_q[IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        refSyncA_q <= refClkStable;
        refSync_q  <= refSyncA_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrlRun_q <= CTRL_RUN_RST;
            restart_q <= 1'b0;
            irqStat_q <= '0;
            irqMask_q <= IRQ_MASK_RST;
            txPrev_q  <= 1'b0;
            rxPrev_q  <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrlRun_q <= avs_writedata[CTRL_RUN];
            end
            restart_q <= (wrCtrl & avs_writedata[CTRL_RESTART]) | (restart_q & ~rstOut_q);
            irqStat_q <= (irqStat_q & ~irqClr) | events;
            if (writeAcc && (avs_address == OFS_IRQ_MASK)) begin
                irqMask_q <= avs_writedata[IRQ_W-1:0];
            end
            txPrev_q <= link.txReady;
            rxPrev_q <= link.rxReady;
        end
    end

    // ***********************************************************************
    // Trigger reset generation.
    // ***********************************************************************
    logic       wantHold;
    logic [1:0] holdCnt_q;
    logic       rstOut_d;

    assign wantHold = ~ctrlRun_q | restart_q | ~refSync_q;
    assign rstOut_d = rstOut_q ? (wantHold | (holdCnt_q < HOLD_LAST)) : wantHold;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rstOut_q  <= 1'b1;
            holdCnt_q <= 2'h0;
        end else begin
            rstOut_q  <= rstOut_d;
            holdCnt_q <= !rstOut_q ? 2'h0 : (holdCnt_q == 2'h3 ? 2'h3 : holdCnt_q + 2'h1);
        end
    end

    // ***********************************************************************
    // Calibration model, reset by the same flop as the trigger.
    // ***********************************************************************
    logic [15:0]       calCnt_q;
    logic [15:0]       calCnt_d;

    always_comb begin
        calState_d = calState_q;
        calCnt_d   = 16'h0;
        case (calState_q)
            CAL_OFF: begin
                if (!rstOut_q) begin
                    calState_d = CAL_FIRST;
                end
            end
            CAL_FIRST: begin
                calState_d = CAL_BUSY;
            end
            CAL_BUSY: begin
                calCnt_d = calCnt_q + 16'h1;
                if (calCnt_q == 16'(CAL_CYCLES - 1)) begin
                    calState_d = CAL_DONE;
                end
            end
            CAL_DONE: begin
                calState_d = CAL_DONE;
            end
            default: begin
                calState_d = CAL_OFF;
            end
        endcase
        if (rstOut_q) begin
            calState_d = CAL_OFF;
        end
    end

    logic calBusy_q;
    logic irq_q;
    logic txUse_q;
    logic rxUse_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            calState_q <= CAL_OFF;
            calCnt_q   <= 16'h0;
            calBusy_q  <= 1'b0;
            irq_q      <= 1'b0;
            txUse_q    <= 1'b0;
            rxUse_q    <= 1'b0;
        end else begin
            calState_q <= calState_d;
            calCnt_q   <= calCnt_d;
            calBusy_q  <= (calState_d == CAL_BUSY);
            irq_q      <= |(((irqStat_q & ~irqClr) | events) & irqMask_q);
            txUse_q    <= link.txReady;
            rxUse_q    <= link.rxReady;
        end
    end

    assign link.seqTrigRst = rstOut_q;
    assign link.calBusy    = calBusy_q;
    assign avs_readdata    = rdData_q;
    assign avs_waitrequest = waitReq_q;
    assign irq             = irq_q;
    assign txUsable        = txUse_q;
    assign rxUsable        = rxUse_q;

endmodule : tsq_controller
`default_nettype wire

// File: tb/tsq_link_asserts.sv
/* Checker for the link between the reset sequencer and its controller.
   Assumes one management clock and a calibration length of 8 cycles. */
`timescale 1ns/100ps
`default_nettype none
module tsq_link_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic seqTrigRst,
    input wire logic calBusy,
    input wire logic txReady,
    input wire logic rxReady,
    input wire logic cdrDataLockFlag,
    input wire logic cdrRefLockFlag
);
    // ********************
    // Link properties.
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_hold_no_rdy: assert property (seqTrigRst[*5] |-> !txReady && !rxReady)
        else $error("ready high while trigger held");
    chk_trig_min_hold: assert property ($rose(seqTrigRst) |=> seqTrigRst)
        else $error("trigger pulse too short");
    chk_cal_first_low: assert property ($fell(seqTrigRst) |-> !calBusy ##[1:3] calBusy)
        else $error("calibration busy timing wrong");
    chk_cal_length: assert property ($rose(calBusy) |-> calBusy[*8] ##1 !calBusy)
        else $error("calibration length wrong");
    chk_tx_rdy_cause: assert property ($rose(txReady) |-> !calBusy && !seqTrigRst && !$past(calBusy, 16))
        else $error("transmit ready too early");
    chk_rx_rdy_cause: assert property ($rose(rxReady) |-> cdrDataLockFlag && $past(cdrDataLockFlag, 40))
        else $error("receive ready without settled lock");
    chk_rx_loss_drop: assert property ($fell(cdrDataLockFlag) |-> ##[0:2] !rxReady)
        else $error("receive ready kept after lock loss");
    chk_data_flag_ok: assert property ($rose(cdrDataLockFlag) |-> !calBusy && !seqTrigRst)
        else $error("data lock flag during reset");
    chk_ref_flag_ok: assert property ($rose(cdrRefLockFlag) |-> !calBusy && !seqTrigRst)
        else $error("reference lock flag during reset");
endmodule : tsq_link_asserts
`default_nettype wire

// File: tb/testbench.sv
/* Testbench joining the sequencer and the controller across the link.
   Assumes two channels and a calibration length of 8 cycles. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tsq_pkg::*;
    logic        sys_clk, rst, pllLock, refClkStable, irq, txUsable, rxUsable, pllPowerdown;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [1:0]  cdrRefLock, cdrDataLock, txPmaReset, txPcsReset, rxPmaReset, rxPcsReset;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          n_mismatch, checked, cyc;
    // ********************
    // Design and checker.
    // ********************
    tsq_link_if lnk ();
    tsq_sequencer #(.NUM_CH(2)) i_tsq_sequencer (.link(lnk), .*);
    tsq_controller #(.CAL_CYCLES(8)) i_tsq_controller (.link(lnk), .*);
    tsq_link_asserts i_tsq_link_asserts (.sys_clk, .rst, .seqTrigRst(lnk.seqTrigRst), .calBusy(lnk.calBusy),
        .txReady(lnk.txReady), .rxReady(lnk.rxReady), .cdrDataLockFlag(lnk.cdrDataLockFlag),
        .cdrRefLockFlag(lnk.cdrRefLockFlag));
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask : bus
    function logic sig(input int s);
        case (s)
            0: return lnk.txReady;
            1: return lnk.rxReady;
            default: return lnk.calBusy;
        endcase
    endfunction : sig
    task wt(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        cmp(32'(sig(s)), 32'(v));
    endtask : wt
    initial begin
        {rst, pllLock, refClkStable, cdrRefLock, cdrDataLock} = 7'h40;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        bus(0, OFS_CTRL, 0); cmp(rd, 32'h1);
        bus(0, OFS_IRQ_MASK, 0); cmp(rd, 32'h0);
        bus(0, 4'h2, 0); cmp(rd, 32'h0);
        repeat (20) @(posedge sys_clk);
        bus(0, OFS_STATUS, 0); cmp(rd, 32'h20);
        bus(1, OFS_IRQ_MASK, 32'hF);
        refClkStable <= 1;
        wt(2, 1, 20);
        wt(2, 0, 20);
        cdrRefLock <= 2'h3;
        repeat (40) @(posedge sys_clk);
        cmp(32'(txPcsReset), 32'h3);
        cmp(32'(lnk.cdrRefLockFlag), 32'h1);
        pllLock <= 1;
        wt(0, 1, 6);
        cmp(32'(txPcsReset), 32'h0);
        cdrDataLock <= 2'h3;
        repeat (60) @(posedge sys_clk);
        cmp(32'(lnk.rxReady), 32'h0);
        wt(1, 1, 40);
        cmp(32'(lnk.cdrDataLockFlag), 32'h1);
        bus(0, OFS_STATUS, 0); cmp(rd, 32'hF);
        cmp(32'({txUsable, rxUsable}), 32'h3);
        cmp(32'(irq), 32'h1);
        bus(0, OFS_IRQ_STAT, 0); cmp(rd, 32'hB);
        repeat (2) @(posedge sys_clk);
        cmp(32'(irq), 32'h0);
        cdrDataLock <= 2'h1;
        wt(1, 0, 6);
        cmp(32'(rxPcsReset), 32'h3);
        cmp(32'(lnk.txReady), 32'h1);
        bus(0, OFS_IRQ_STAT, 0); cmp(rd, 32'h4);
        cmp(32'({txUsable, rxUsable}), 32'h2);
        cdrDataLock <= 2'h3;
        wt(1, 1, 100);
        bus(0, OFS_IRQ_STAT, 0); cmp(rd, 32'h2);
        bus(1, OFS_IRQ_MASK, 32'h3);
        bus(1, OFS_CTRL, 0);
        repeat (20) @(posedge sys_clk);
        bus(0, OFS_STATUS, 0); cmp(rd, 32'h20);
        cmp(32'({pllPowerdown, txPmaReset, rxPmaReset}), 32'h1F);
        cmp(32'({txUsable, rxUsable, irq}), 32'h0);
        bus(0, OFS_IRQ_STAT, 0); cmp(rd, 32'h4);
        bus(1, OFS_CTRL, 1);
        wt(0, 1, 200);
        wt(1, 1, 200);
        cmp(32'(irq), 32'h1);
        bus(1, OFS_CTRL, 3);
        bus(0, OFS_CTRL, 0); cmp(rd, 32'h1);
        repeat (6) @(posedge sys_clk);
        cmp(32'(lnk.txReady), 32'h0);
        wt(0, 1, 200);
        conclude();
    end
endmodule : testbench
`default_nettype wire
